// ### rtl/led_consts.svh
// constants for the port status indicator and serial status block
`ifndef LED_CONSTS_SVH
`define LED_CONSTS_SVH

// clock and times
`define CLK_MHZ          50
`define PERIOD_US        1000
`define GAP_US           10
`define STRETCH_US       50000
`define US_TO_CYC(us)    ((us) * `CLK_MHZ)

// frame layout
`define PORTS            4
`define FRAME_BITS       24
`define BITS_PER_PORT    6
`define PORT0_MSB        23
`define F_TX             5
`define F_RX             4
`define F_LINK           3
`define F_DUP            2
`define F_SPD            1
`define F_COL            0
`define BIT_CNT_W        5

// register map
`define ADDR_W           12
`define REG_CTRL         12'h000
`define REG_STAT         12'h004
`define CTRL_W           8
`define CTRL_RESET       8'h00
`define CTRL_NOSTRETCH   0
`define CTRL_SEL1_LSB    2
`define CTRL_SEL2_LSB    4
`define CTRL_SEL3_LSB    6
`define SEL_W            2
`define STAT_BUSY        24
`define STAT_PEND        25

// reset and idle levels
`define IND_OFF          4'hF
`define SER_IDLE         1'b0

`endif

// ### rtl/led_pkg.sv
// types shared by the status indicator block
`default_nettype none
package led_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_GAP
    } frame_state_type;

endpackage
`default_nettype wire

// ### rtl/pulse_stretch.sv
// on-time stretcher for one indicator condition
`default_nettype none
module pulse_stretch #(
    parameter int CYCLES = 1
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control and condition
    input  wire logic bypass,
    input  wire logic cond,
    output logic      on
);
    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    wire           running = (cnt_q != '0);

    // reload while the condition is present, then run down
    assign cnt_d = cond    ? CW'(CYCLES)
                 : running ? cnt_q - 1'b1
                 : cnt_q;

    assign on = cond | (~bypass & running);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // pulse_stretch
`default_nettype wire

// ### rtl/port_status_led_serializer.sv
// serial status frame and per-port indicator drivers with apb control
`default_nettype none
`include "led_consts.svh"
module port_status_led_serializer #(
    parameter int PERIOD_CYCLES  = `US_TO_CYC(`PERIOD_US),
    parameter int STRETCH_CYCLES = `US_TO_CYC(`STRETCH_US)
) (
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [`ADDR_W-1:0]  paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // per-port conditions, asynchronous
    input  wire logic [`PORTS-1:0]   tx_active,
    input  wire logic [`PORTS-1:0]   rx_active,
    input  wire logic [`PORTS-1:0]   link_up,
    input  wire logic [`PORTS-1:0]   full_duplex,
    input  wire logic [`PORTS-1:0]   speed_10,
    // serial status
    output logic                     status_serial_out,
    output logic                     status_frame_strobe,
    // per-port indicators, active low
    output logic [`PORTS-1:0]        port_indicator_first_n,
    output logic [`PORTS-1:0]        port_indicator_second_n,
    output logic [`PORTS-1:0]        port_indicator_third_n
);
    localparam int NIN = 5 * `PORTS;
    localparam int PW  = $clog2(PERIOD_CYCLES + 1);
    localparam int GAP_CYCLES = `US_TO_CYC(`GAP_US);
    localparam int GW  = $clog2(GAP_CYCLES + 1);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [NIN-1:0] sync1_q;
    logic [NIN-1:0] sync2_q;
    logic [NIN-1:0] sync3_q;
    logic [NIN-1:0] stable_q;
    logic [NIN-1:0] stable_d;
    wire  [NIN-1:0] raw_in = {speed_10, full_duplex, link_up,
                              rx_active, tx_active};

    // take a bit only once stages two and three agree
    assign stable_d = (sync2_q & sync3_q)
                    | (stable_q & (sync2_q ^ sync3_q));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q  <= '0;
            sync2_q  <= '0;
            sync3_q  <= '0;
            stable_q <= '0;
        end else begin
            sync1_q  <= raw_in;
            sync2_q  <= sync1_q;
            sync3_q  <= sync2_q;
            stable_q <= stable_d;
        end
    end

    wire [`PORTS-1:0] tx_s  = stable_q[0*`PORTS +: `PORTS];
    wire [`PORTS-1:0] rx_s  = stable_q[1*`PORTS +: `PORTS];
    wire [`PORTS-1:0] lnk_s = stable_q[2*`PORTS +: `PORTS];
    wire [`PORTS-1:0] fdx_s = stable_q[3*`PORTS +: `PORTS];
    wire [`PORTS-1:0] s10_s = stable_q[4*`PORTS +: `PORTS];
    wire [`PORTS-1:0] col_s = tx_s & rx_s;

    // ------------------------------------------------------------
    // frame assembly
    // ------------------------------------------------------------
    function automatic logic [`FRAME_BITS-1:0] build_frame(
        input logic [`PORTS-1:0] tx,
        input logic [`PORTS-1:0] rx,
        input logic [`PORTS-1:0] lnk,
        input logic [`PORTS-1:0] fdx,
        input logic [`PORTS-1:0] s10,
        input logic [`PORTS-1:0] col
    );
        logic [`FRAME_BITS-1:0] f;
        int                     base;
        f = '0;
        for (int p = 0; p < `PORTS; p++) begin
            base = `PORT0_MSB - `BITS_PER_PORT * p - (`BITS_PER_PORT - 1);
            f[base + `F_TX]   = ~tx[p];
            f[base + `F_RX]   = ~rx[p];
            f[base + `F_LINK] = ~lnk[p];
            f[base + `F_DUP]  = fdx[p];
            f[base + `F_SPD]  = s10[p];
            f[base + `F_COL]  = ~col[p];
        end
        return f;
    endfunction

    wire [`FRAME_BITS-1:0] frame_now =
        build_frame(tx_s, rx_s, lnk_s, fdx_s, s10_s, col_s);

    // ------------------------------------------------------------
    // burst scheduling
    // ------------------------------------------------------------
    led_pkg::frame_state_type state_q;
    led_pkg::frame_state_type state_d;

    logic [`FRAME_BITS-1:0] frame_prev_q;
    logic [`FRAME_BITS-1:0] sent_q;
    logic [`FRAME_BITS-1:0] sent_d;
    logic [`FRAME_BITS-1:0] shreg_q;
    logic [`FRAME_BITS-1:0] shreg_d;
    logic [`BIT_CNT_W-1:0]  bit_cnt_q;
    logic [`BIT_CNT_W-1:0]  bit_cnt_d;
    logic [PW-1:0]          period_cnt_q;
    logic [PW-1:0]          period_cnt_d;
    logic [GW-1:0]          gap_cnt_q;
    logic [GW-1:0]          gap_cnt_d;
    logic                   pend_q;
    logic                   pend_d;
    logic                   ser_q;
    logic                   ser_d;
    logic                   strobe_q;
    logic                   strobe_d;

    wire in_idle  = (state_q == led_pkg::ST_IDLE);
    wire in_shift = (state_q == led_pkg::ST_SHIFT);
    wire in_gap   = (state_q == led_pkg::ST_GAP);

    wire changed    = (frame_now != frame_prev_q);
    // saturates until the next burst start
    wire period_hit = (period_cnt_q == PW'(PERIOD_CYCLES - 1));
    wire start      = in_idle & (period_hit | pend_q);
    wire bit_last   = (bit_cnt_q == `BIT_CNT_W'(`FRAME_BITS - 1));
    wire gap_done   = (gap_cnt_q == GW'(GAP_CYCLES - 1));

    // a change in the clearing cycle still counts
    assign pend_d = changed | (pend_q & ~start);

    assign period_cnt_d = start      ? '0
                        : period_hit ? period_cnt_q
                        : period_cnt_q + 1'b1;

    assign gap_cnt_d = in_gap ? gap_cnt_q + 1'b1 : '0;

    // snapshot all bits at the burst start
    assign sent_d = start ? frame_now : sent_q;

    assign shreg_d = start    ? frame_now
                   : in_shift ? {shreg_q[`FRAME_BITS-2:0], 1'b0}
                   : shreg_q;

    assign bit_cnt_d = in_shift ? bit_cnt_q + 1'b1 : '0;

    // msb first, strobe exactly over the data bits
    assign ser_d    = in_shift ? shreg_q[`FRAME_BITS-1]
                    : `SER_IDLE;
    assign strobe_d = in_shift;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            led_pkg::ST_IDLE: begin
                if (start) begin
                    state_d = led_pkg::ST_SHIFT;
                end
            end
            led_pkg::ST_SHIFT: begin
                if (bit_last) begin
                    state_d = led_pkg::ST_GAP;
                end
            end
            led_pkg::ST_GAP: begin
                if (gap_done) begin
                    state_d = led_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = led_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q      <= led_pkg::ST_IDLE;
            frame_prev_q <= '0;
            sent_q       <= '0;
            shreg_q      <= '0;
            bit_cnt_q    <= '0;
            period_cnt_q <= '0;
            gap_cnt_q    <= '0;
            pend_q       <= 1'b0;
            ser_q        <= `SER_IDLE;
            strobe_q     <= 1'b0;
        end else begin
            state_q      <= state_d;
            frame_prev_q <= frame_now;
            sent_q       <= sent_d;
            shreg_q      <= shreg_d;
            bit_cnt_q    <= bit_cnt_d;
            period_cnt_q <= period_cnt_d;
            gap_cnt_q    <= gap_cnt_d;
            pend_q       <= pend_d;
            ser_q        <= ser_d;
            strobe_q     <= strobe_d;
        end
    end

    assign status_serial_out   = ser_q;
    assign status_frame_strobe = strobe_q;

    // ------------------------------------------------------------
    // apb register slave
    // ------------------------------------------------------------
    logic [`CTRL_W-1:0] ctrl_q;
    logic [`CTRL_W-1:0] ctrl_d;
    logic [31:0]        prdata_q;
    logic [31:0]        prdata_d;
    logic               pready_q;
    logic               pslverr_q;

    wire setup    = psel & ~penable;
    wire access   = psel & penable & pready_q;
    wire hit_ctrl = (paddr == `REG_CTRL);
    wire hit_stat = (paddr == `REG_STAT);
    wire mapped   = hit_ctrl | hit_stat;

    wire [31:0] stat_word = {6'h00, pend_q, ~in_idle, sent_q};
    wire [31:0] ctrl_word = {24'h000000, ctrl_q};
    wire [31:0] rd_word   = hit_ctrl ? ctrl_word
                          : hit_stat ? stat_word
                          : 32'h00000000;

    assign ctrl_d = (access & pwrite & hit_ctrl)
                  ? pwdata[`CTRL_W-1:0] : ctrl_q;
    assign prdata_d = (setup & ~pwrite) ? rd_word : prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= `CTRL_RESET;
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            prdata_q  <= prdata_d;
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    wire nostretch = ctrl_q[`CTRL_NOSTRETCH];
    wire [`SEL_W-1:0] sel1 = ctrl_q[`CTRL_SEL1_LSB +: `SEL_W];
    wire [`SEL_W-1:0] sel2 = ctrl_q[`CTRL_SEL2_LSB +: `SEL_W];
    wire [`SEL_W-1:0] sel3 = ctrl_q[`CTRL_SEL3_LSB +: `SEL_W];

    // ------------------------------------------------------------
    // per-port indicators
    // ------------------------------------------------------------
    function automatic logic pick(
        input logic [`SEL_W-1:0] sel,
        input logic [3:0]        cond
    );
        return cond[sel];
    endfunction

    logic [`PORTS-1:0] cond1;
    logic [`PORTS-1:0] cond2;
    logic [`PORTS-1:0] cond3;
    logic [`PORTS-1:0] on1;
    logic [`PORTS-1:0] on2;
    logic [`PORTS-1:0] on3;
    wire  [`PORTS-1:0] s100_s = ~s10_s;

    for (genvar p = 0; p < `PORTS; p++) begin : g_port
        assign cond1[p] = pick(sel1, {fdx_s[p], lnk_s[p],
                                      rx_s[p], tx_s[p]});
        assign cond2[p] = pick(sel2, {s100_s[p], fdx_s[p],
                                      lnk_s[p], rx_s[p]});
        assign cond3[p] = pick(sel3, {col_s[p], s100_s[p],
                                      fdx_s[p], lnk_s[p]});

        pulse_stretch #(
            .CYCLES (STRETCH_CYCLES)
        ) u_str1 (
            .pclk    (pclk),
            .presetn (presetn),
            .bypass  (nostretch),
            .cond    (cond1[p]),
            .on      (on1[p])
        );
        pulse_stretch #(
            .CYCLES (STRETCH_CYCLES)
        ) u_str2 (
            .pclk    (pclk),
            .presetn (presetn),
            .bypass  (nostretch),
            .cond    (cond2[p]),
            .on      (on2[p])
        );
        pulse_stretch #(
            .CYCLES (STRETCH_CYCLES)
        ) u_str3 (
            .pclk    (pclk),
            .presetn (presetn),
            .bypass  (nostretch),
            .cond    (cond3[p]),
            .on      (on3[p])
        );
    end

    logic [`PORTS-1:0] ind1_q;
    logic [`PORTS-1:0] ind2_q;
    logic [`PORTS-1:0] ind3_q;

    // drive low while on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ind1_q <= `IND_OFF;
            ind2_q <= `IND_OFF;
            ind3_q <= `IND_OFF;
        end else begin
            ind1_q <= ~on1;
            ind2_q <= ~on2;
            ind3_q <= ~on3;
        end
    end

    assign port_indicator_first_n  = ind1_q;
    assign port_indicator_second_n = ind2_q;
    assign port_indicator_third_n  = ind3_q;
endmodule // port_status_led_serializer
`default_nettype wire

// ### testbench/led_checker_sva.sv
// assertion checker for the serial status frame and indicator outputs
`default_nettype none
`include "led_consts.svh"
module led_checker #(
    parameter int PERIOD_CYCLES  = 1,
    parameter int STRETCH_CYCLES = 1
) (
    // clock and reset
    input wire logic               pclk,
    input wire logic               presetn,
    // apb writes
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0]        pwdata,
    input wire logic               pready,
    // conditions
    input wire logic [`PORTS-1:0]  tx_active,
    input wire logic [`PORTS-1:0]  link_up,
    // outputs
    input wire logic               status_serial_out,
    input wire logic               status_frame_strobe,
    input wire logic [`PORTS-1:0]  port_indicator_first_n,
    input wire logic [`PORTS-1:0]  port_indicator_third_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire        ctrl_wr = psel && penable && pready && pwrite
                          && paddr == `REG_CTRL;
    logic [7:0] ctrl_q;
    logic       seen_q;
    int         high_q;
    int         low_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 8'h00;
            seen_q <= 1'b0;
            high_q <= 0;
            low_q  <= 0;
        end else begin
            if (ctrl_wr) begin
                ctrl_q <= pwdata[7:0];
            end
            seen_q <= seen_q | status_frame_strobe;
            high_q <= status_frame_strobe ? high_q + 1 : 0;
            low_q  <= status_frame_strobe ? 0 : low_q + 1;
        end
    end
    sequence s_start;
        ##[1:600] $rose(status_frame_strobe);
    endsequence
    property p_strobe_len;
        $fell(status_frame_strobe) |-> high_q == `FRAME_BITS;
    endproperty
    a_strobe_len: assert property (p_strobe_len)
        else $error("strobe length wrong");
    property p_idle;
        !status_frame_strobe |-> !status_serial_out;
    endproperty
    a_idle: assert property (p_idle)
        else $error("data driven outside frame");
    property p_gap;
        $rose(status_frame_strobe) && seen_q |-> low_q >= 500;
    endproperty
    a_gap: assert property (p_gap)
        else $error("inter-burst gap too short");
    property p_period;
        !status_frame_strobe |-> low_q < PERIOD_CYCLES + 4;
    endproperty
    a_period: assert property (p_period)
        else $error("periodic burst missing");
    property p_change;
        $changed(link_up) |-> s_start;
    endproperty
    a_change: assert property (p_change)
        else $error("no burst after status change");
    property p_ind_first;
        $rose(tx_active[0]) && ctrl_q[3:2] == 2'h0
            |-> ##[2:6] !port_indicator_first_n[0];
    endproperty
    a_ind_first: assert property (p_ind_first)
        else $error("first indicator missed transmit");
    property p_ind_third;
        $rose(link_up[3]) && ctrl_q[7:6] == 2'h0
            |-> ##[2:6] !port_indicator_third_n[3];
    endproperty
    a_ind_third: assert property (p_ind_third)
        else $error("third indicator missed link");
    property p_stretch;
        $fell(port_indicator_first_n[0]) && ctrl_q[3:0] == 4'h0
            |-> !port_indicator_first_n[0] [*8];
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("indicator on-time not stretched");
endmodule // led_checker
bind port_status_led_serializer led_checker #(
    .PERIOD_CYCLES  (PERIOD_CYCLES),
    .STRETCH_CYCLES (STRETCH_CYCLES)
) led_checker_i (.*);
`default_nettype wire

// ### testbench/status_shift_reg.sv
// outside shift register model capturing each serial status frame
`default_nettype none
module status_shift_reg (
    // clock
    input  wire logic   pclk,
    // serial status from the block
    input  wire logic   status_serial_out,
    input  wire logic   status_frame_strobe,
    // captured frame
    output logic [23:0] frame,
    output logic        frame_done,
    output logic [5:0]  bit_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] shift_q  = 24'h000000;
    logic [5:0]  count_q  = 6'h00;
    logic        strobe_q = 1'b0;
    always @(posedge pclk) begin
        strobe_q   <= status_frame_strobe;
        frame_done <= strobe_q && !status_frame_strobe;
        if (status_frame_strobe) begin
            shift_q <= {shift_q[22:0], status_serial_out};
            count_q <= count_q + 6'h01;
        end else if (strobe_q) begin
            frame     <= shift_q;
            bit_count <= count_q;
            count_q   <= 6'h00;
        end
    end
endmodule // status_shift_reg
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the serial status frame and indicator block
`default_nettype none
`include "led_consts.svh"
`define CHECK_EQ(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("unexpected at %0t: %h vs %h", $time, got, exp); \
    end \
end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PER = 600;
    localparam int STR = 10;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  tx_active = 4'h0;
    logic [3:0]  rx_active = 4'h0;
    logic [3:0]  link_up = 4'h0;
    logic [3:0]  full_duplex = 4'h0;
    logic [3:0]  speed_10 = 4'h0;
    logic        status_serial_out;
    logic        status_frame_strobe;
    logic [3:0]  port_indicator_first_n;
    logic [3:0]  port_indicator_second_n;
    logic [3:0]  port_indicator_third_n;
    logic [23:0] frame;
    logic        frame_done;
    logic [5:0]  bit_count;
    int          err_count = 0;
    int          compares = 0;
    int          cyc = 0;
    port_status_led_serializer #(
        .PERIOD_CYCLES  (PER),
        .STRETCH_CYCLES (STR)
    ) port_status_led_serializer_i (.*);
    status_shift_reg status_shift_reg_i (.*);
    initial begin
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;
    task automatic complete_run();
        if (err_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic expire();
        err_count++;
        complete_run();
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) expire();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic drive(input logic [3:0] t, r, l, f, s);
        tx_active <= t;
        rx_active <= r;
        link_up <= l;
        full_duplex <= f;
        speed_10 <= s;
        @(posedge pclk);
    endtask
    task automatic get_frame(output logic [23:0] f);
        int k;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (frame_done !== 1'b1 && k < 2000);
        if (frame_done !== 1'b1) expire();
        f = frame;
    endtask
    // expected frame from the levels now driven
    function automatic logic [23:0] exp_frame();
        logic [23:0] e;
        for (int p = 0; p < 4; p++) begin
            e[23-6*p -: 6] = {~tx_active[p], ~rx_active[p], ~link_up[p],
                full_duplex[p], speed_10[p], ~(tx_active[p] & rx_active[p])};
        end
        return e;
    endfunction
    task automatic t_regs();
        logic [31:0] q;
        logic        e;
        apb(1'b0, `REG_CTRL, 32'h0, q, e);
        `CHECK_EQ(q, 32'h0)
        apb(1'b1, `REG_CTRL, 32'hFF, q, e);
        apb(1'b0, `REG_CTRL, 32'h0, q, e);
        `CHECK_EQ(q, 32'hFF)
        apb(1'b0, 12'h008, 32'h0, q, e);
        `CHECK_EQ({e, q}, 33'h100000000)
        apb(1'b1, `REG_CTRL, 32'h0, q, e);
    endtask
    task automatic t_frames();
        logic [23:0] f;
        logic [19:0] pat [4] = '{20'h00000, 20'h53AC9, 20'hFFFFF,
                                 20'hA6536};
        foreach (pat[i]) begin
            drive(pat[i][19:16], pat[i][15:12], pat[i][11:8],
                  pat[i][7:4], pat[i][3:0]);
            get_frame(f);
            get_frame(f);
            `CHECK_EQ(f, exp_frame())
            `CHECK_EQ(bit_count, 6'h18)
        end
    endtask
    task automatic t_period();
        logic [23:0] f;
        logic [23:0] old;
        logic [31:0] q;
        logic        e;
        int          t0;
        int          k;
        get_frame(f);
        t0 = cyc;
        get_frame(old);
        `CHECK_EQ(cyc - t0, PER)
        k = 0;
        while (status_frame_strobe !== 1'b1 && k < PER + 50) begin
            @(posedge pclk);
            k++;
        end
        if (status_frame_strobe !== 1'b1) expire();
        repeat (8) @(posedge pclk);
        drive(4'h0, 4'hF, 4'h3, 4'h5, 4'hC);
        get_frame(f);
        t0 = cyc;
        `CHECK_EQ(f, old)
        get_frame(f);
        `CHECK_EQ(f, exp_frame())
        `CHECK_EQ((cyc - t0) inside {[525:530]}, 1'b1)
        // engine in its gap, nothing pending, last frame kept
        apb(1'b0, `REG_STAT, 32'h0, q, e);
        `CHECK_EQ({e, q}, {9'h001, exp_frame()})
    endtask
    task automatic t_ind();
        logic [31:0] q;
        logic        e;
        logic [3:0]  v [6];
        drive(4'h5, 4'h3, 4'hA, 4'hC, 4'h9);
        v = '{4'h5, 4'h3, 4'hA, 4'hC, 4'h6, 4'h1};
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `REG_CTRL, 32'h54 * s + 32'h1, q, e);
            repeat (8) @(posedge pclk);
            `CHECK_EQ(port_indicator_first_n, ~v[s])
            `CHECK_EQ(port_indicator_second_n, ~v[s+1])
            `CHECK_EQ(port_indicator_third_n, ~v[s+2])
        end
    endtask
    task automatic t_stretch();
        logic [31:0] q;
        logic        e;
        apb(1'b1, `REG_CTRL, 32'h0, q, e);
        drive(4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        repeat (STR + 8) @(posedge pclk);
        drive(4'h1, 4'h0, 4'h8, 4'h0, 4'h0);
        repeat (6) @(posedge pclk);
        `CHECK_EQ(port_indicator_first_n, 4'hE)
        `CHECK_EQ(port_indicator_second_n, 4'hF)
        `CHECK_EQ(port_indicator_third_n, 4'h7)
        drive(4'h0, 4'h0, 4'h8, 4'h0, 4'h0);
        repeat (STR - 2) @(posedge pclk);
        `CHECK_EQ(port_indicator_first_n[0], 1'b0)
        repeat (8) @(posedge pclk);
        `CHECK_EQ(port_indicator_first_n[0], 1'b1)
        // stretch off: indicator follows the condition at once
        apb(1'b1, `REG_CTRL, 32'h1, q, e);
        drive(4'h1, 4'h0, 4'h8, 4'h0, 4'h0);
        repeat (6) @(posedge pclk);
        `CHECK_EQ(port_indicator_first_n[0], 1'b0)
        drive(4'h0, 4'h0, 4'h8, 4'h0, 4'h0);
        repeat (6) @(posedge pclk);
        `CHECK_EQ(port_indicator_first_n[0], 1'b1)
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_frames();
        t_period();
        t_ind();
        t_stretch();
        complete_run();
    end
endmodule // testbench
`default_nettype wire
